// ==== rtcdt_regs.sv ====
// Date and time holding registers with a free-running calendar.
// Assumes a register port decoded by a protocol front end on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rtcdt_regs #(
   parameter int CYC_PER_MS = rtcdt_pkg::RTCDT_CYC_PER_MS
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_hit,
   output logic err_status_bit,
   output logic [31:0] err_word
);
   import rtcdt_pkg::*;

   // ------------------------------------------------------------
   // Types and state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] month;
      logic [7:0] year;
      logic [7:0] hour;
      logic [7:0] day;
      logic [7:0] sec;
      logic [7:0] min;
      logic [15:0] ms;
      logic [15:0] sh_my;
      logic [15:0] sh_hd;
      logic [15:0] sh_sm;
      logic valid;
      logic [15:0] rdata;
   } rtcdt_state_t;

   rtcdt_state_t st_r;
   rtcdt_state_t st_nxt;
   logic tick;
   logic commit;

   // Days in a month; year is two-digit, leap when divisible by four.
   function automatic logic [7:0] rtcdt_mdays(input logic [7:0] m, input logic [7:0] y);
      case (m)
         8'h02: rtcdt_mdays = (y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
         8'h04, 8'h06, 8'h09, 8'h0B: rtcdt_mdays = 8'h1E;
         default: rtcdt_mdays = RTCDT_DAY_MAX;
      endcase
   endfunction : rtcdt_mdays

   // Checks one full date and time for range errors.
   function automatic logic rtcdt_ok(input logic [7:0] mo, input logic [7:0] yr,
                                     input logic [7:0] hr, input logic [7:0] dy,
                                     input logic [7:0] sc, input logic [7:0] mi,
                                     input logic [15:0] ms);
      rtcdt_ok = (mo != 8'h00) && (mo <= RTCDT_MONTH_MAX) && (yr <= RTCDT_YEAR_MAX) &&
                 (hr <= RTCDT_HOUR_MAX) && (dy != 8'h00) && (dy <= rtcdt_mdays(mo, yr)) &&
                 (sc <= RTCDT_SEC_MAX) && (mi <= RTCDT_MIN_MAX) && (ms <= RTCDT_MS_MAX);
   endfunction : rtcdt_ok

   assign commit = reg_wr && (reg_addr == RTCDT_ADDR_MS); // RULE6

   rtcdt_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
      .clk(clk),
      .sys_rst(sys_rst),
      .restart(commit),
      .tick(tick)
   );

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   // Stages the paired fields, commits on milliseconds, and counts time.
   always_comb begin
      st_nxt = st_r;
      if (reg_wr) begin
         case (reg_addr)
            RTCDT_ADDR_MY: st_nxt.sh_my = reg_wdata; // RULE4
            RTCDT_ADDR_HD: st_nxt.sh_hd = reg_wdata; // RULE4
            RTCDT_ADDR_SM: st_nxt.sh_sm = reg_wdata; // RULE4
            default: st_nxt.sh_my = st_r.sh_my;
         endcase
      end
      if (commit) begin
         // All seven fields load at once, upper byte first-named.
         st_nxt.month = st_r.sh_my[15:RTCDT_HI_LSB]; // RULE8
         st_nxt.year = st_r.sh_my[RTCDT_HI_LSB-1:0];
         st_nxt.hour = st_r.sh_hd[15:RTCDT_HI_LSB];
         st_nxt.day = st_r.sh_hd[RTCDT_HI_LSB-1:0];
         st_nxt.sec = st_r.sh_sm[15:RTCDT_HI_LSB];
         st_nxt.min = st_r.sh_sm[RTCDT_HI_LSB-1:0];
         st_nxt.ms = reg_wdata;
         // Hour 24 is taken as midnight.
         if (st_r.sh_hd[15:RTCDT_HI_LSB] == RTCDT_HOUR_MAX + 8'h01) begin
            st_nxt.hour = 8'h00; // RULE3
         end
         st_nxt.valid = rtcdt_ok(st_nxt.month, st_nxt.year, st_nxt.hour, st_nxt.day,
                                 st_nxt.sec, st_nxt.min, st_nxt.ms); // RULE3
      end else if (tick && st_r.valid) begin
         // Calendar carry chain; runs while the time is valid, and stops invalid when year 50 ends.
         if (st_r.ms != RTCDT_MS_MAX) begin // RULE1
            st_nxt.ms = st_r.ms + 16'h0001;
         end else begin
            st_nxt.ms = 16'h0000;
            if (st_r.sec != RTCDT_SEC_MAX) begin
               st_nxt.sec = st_r.sec + 8'h01;
            end else begin
               st_nxt.sec = 8'h00;
               if (st_r.min != RTCDT_MIN_MAX) begin
                  st_nxt.min = st_r.min + 8'h01;
               end else begin
                  st_nxt.min = 8'h00;
                  if (st_r.hour != RTCDT_HOUR_MAX) begin
                     st_nxt.hour = st_r.hour + 8'h01;
                  end else begin
                     st_nxt.hour = 8'h00;
                     if (st_r.day != rtcdt_mdays(st_r.month, st_r.year)) begin
                        st_nxt.day = st_r.day + 8'h01;
                     end else begin
                        st_nxt.day = 8'h01;
                        if (st_r.month != RTCDT_MONTH_MAX) begin
                           st_nxt.month = st_r.month + 8'h01;
                        end else begin
                           st_nxt.month = 8'h01;
                           if (st_r.year != RTCDT_YEAR_MAX) begin
                              st_nxt.year = st_r.year + 8'h01;
                           end else begin
                              st_nxt.year = 8'h00;
                              st_nxt.valid = 1'b0;
                           end
                        end
                     end
                  end
               end
            end
         end
      end
      // Read data shows the live clock in the write layout.
      case (reg_addr)
         RTCDT_ADDR_MY: st_nxt.rdata = {st_r.month, st_r.year}; // RULE7
         RTCDT_ADDR_HD: st_nxt.rdata = {st_r.hour, st_r.day}; // RULE7
         RTCDT_ADDR_SM: st_nxt.rdata = {st_r.sec, st_r.min}; // RULE7
         RTCDT_ADDR_MS: st_nxt.rdata = st_r.ms; // RULE7
         default: st_nxt.rdata = 16'h0000;
      endcase
      if (!reg_rd) begin
         st_nxt.rdata = st_r.rdata;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   // Reset stands for loss of the backup store: time becomes invalid.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign reg_hit = (reg_addr >= RTCDT_ADDR_MY) && (reg_addr <= RTCDT_ADDR_MS);
   assign err_status_bit = !st_r.valid; // RULE9
   assign err_word = 32'(err_status_bit) << RTCDT_ERR_BIT; // RULE9

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // Commit and hold checks.
   a_commit_loads: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
      commit |=> (st_r.ms == $past(reg_wdata)) && (st_r.min == $past(st_r.sh_sm[7:0])))
      else $error("commit did not load fields");
   a_hold_nocommit: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
      (!commit && !tick) |=> $stable(st_r.ms) && $stable(st_r.month))
      else $error("clock moved without commit or tick");
   a_read_layout: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
      (reg_rd && reg_addr == RTCDT_ADDR_MY) |=> reg_rdata == $past({st_r.month, st_r.year}))
      else $error("month year readback wrong");
   a_read_unmapped: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
      (reg_rd && !reg_hit) |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   // A staged month of zero or past December must raise the error bit.
   a_err_flag: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
      (commit && (st_r.sh_my[15:RTCDT_HI_LSB] == 8'h00 || st_r.sh_my[15:RTCDT_HI_LSB] > RTCDT_MONTH_MAX))
      |=> err_status_bit && err_word[RTCDT_ERR_BIT])
      else $error("bad month did not raise the error bit");
   a_ranges_ok: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
      st_r.valid |-> st_r.hour <= RTCDT_HOUR_MAX && st_r.month <= RTCDT_MONTH_MAX)
      else $error("valid clock out of range");
   a_ms_advance: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
      (tick && st_r.valid && !commit && st_r.ms < RTCDT_MS_MAX) |=> st_r.ms == $past(st_r.ms) + 16'h0001)
      else $error("milliseconds did not advance");
   a_hour_wrap: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
      (commit && st_r.sh_hd[15:8] == 8'h18) |=> st_r.hour == 8'h00)
      else $error("hour 24 not taken as 0");
   a_ms_wrap: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
      (tick && st_r.valid && !commit && st_r.ms == RTCDT_MS_MAX) |=> st_r.ms == 16'h0000)
      else $error("milliseconds did not wrap");
   // Staging writes must leave the running clock alone until the commit.
   a_stage_quiet: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
      (reg_wr && reg_addr == RTCDT_ADDR_MY && !tick) |=> $stable(st_r.month) && $stable(st_r.year))
      else $error("staging write changed the clock");
   // The milliseconds register reads back the live count.
   a_read_ms: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
      (reg_rd && reg_addr == RTCDT_ADDR_MS) |=> reg_rdata == $past(st_r.ms))
      else $error("milliseconds readback wrong");
   // A full day rollover starts the next day at 1 and midnight.
   a_day_wrap: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
      (tick && st_r.valid && !commit && st_r.ms == RTCDT_MS_MAX && st_r.sec == RTCDT_SEC_MAX &&
       st_r.min == RTCDT_MIN_MAX && st_r.hour == RTCDT_HOUR_MAX && st_r.day == RTCDT_DAY_MAX)
      |=> st_r.day == 8'h01 && st_r.hour == 8'h00)
      else $error("day did not roll over");

   c_commit: cover property (@(posedge clk) commit ##1 st_r.valid);
   c_bad_commit: cover property (@(posedge clk) commit ##1 !st_r.valid);
   c_second_roll: cover property (@(posedge clk) st_r.valid && st_r.ms == RTCDT_MS_MAX && tick);
   c_readback: cover property (@(posedge clk) reg_rd && reg_addr == RTCDT_ADDR_MS);
   c_hour_24: cover property (@(posedge clk) commit && st_r.sh_hd[15:RTCDT_HI_LSB] == RTCDT_HOUR_MAX + 8'h01);
endmodule : rtcdt_regs
`default_nettype wire

// ==== rtcdt_pkg.sv ====
// Package of constants for the date and time register block.
// Assumes a single 100 MHz clock and a holding-register access port.
// Contract
// RULE1 - Clock keeps counting while backup power holds; the code stops it, invalid, when year 50 ends
// RULE2 - Master sets time at install and after outage
// RULE3 - Fields are binary with documented ranges
// RULE4 - Four holding registers at 175 to 178
// RULE5 - Master writes zero milliseconds when setting
// RULE6 - Milliseconds write commits the whole date
// RULE7 - Reads return current date and time
// RULE8 - First field upper byte, second lower byte
// RULE9 - Error bit 8 flags invalid date time
package rtcdt_pkg;
   localparam logic [7:0] RTCDT_ADDR_MY = 8'hAF;
   localparam logic [7:0] RTCDT_ADDR_HD = 8'hB0;
   localparam logic [7:0] RTCDT_ADDR_SM = 8'hB1;
   localparam logic [7:0] RTCDT_ADDR_MS = 8'hB2;
   localparam int RTCDT_HI_LSB = 8;
   localparam int RTCDT_ERR_BIT = 8;
   localparam logic [7:0] RTCDT_MONTH_MAX = 8'h0C;
   localparam logic [7:0] RTCDT_YEAR_MAX = 8'h32;
   localparam logic [7:0] RTCDT_DAY_MAX = 8'h1F;
   localparam logic [7:0] RTCDT_HOUR_MAX = 8'h17;
   localparam logic [7:0] RTCDT_SEC_MAX = 8'h3B;
   localparam logic [7:0] RTCDT_MIN_MAX = 8'h3B;
   localparam logic [15:0] RTCDT_MS_MAX = 16'h03E7;
   localparam int RTCDT_CLK_HZ = 100000000;
   localparam int RTCDT_MS_PER_S = 1000;
   localparam int RTCDT_CYC_PER_MS = RTCDT_CLK_HZ / RTCDT_MS_PER_S;
endpackage : rtcdt_pkg

// ==== rtcdt_tick.sv ====
// Millisecond tick generator for the date and time block.
// Assumes the system clock at the rate given in the package.
`timescale 1ns/1ps
`default_nettype none
module rtcdt_tick #(
   parameter int CYC_PER_MS = rtcdt_pkg::RTCDT_CYC_PER_MS
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic restart,
   output logic tick
);
   import rtcdt_pkg::*;
   typedef struct packed {
      logic [31:0] cnt;
   } rtcdt_tick_state_t;
   rtcdt_tick_state_t st_r;
   rtcdt_tick_state_t st_nxt;
   localparam logic [31:0] TOP = 32'(CYC_PER_MS - 1);

   // Counts clock cycles and restarts the phase on a commit.
   always_comb begin
      st_nxt = st_r;
      if (restart || st_r.cnt == TOP) begin
         st_nxt.cnt = '0;
      end else begin
         st_nxt.cnt = st_r.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick = (st_r.cnt == TOP) && !restart;

   a_tick_period: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
      tick |=> !tick) else $error("tick lasted longer than one cycle");
endmodule : rtcdt_tick
`default_nettype wire

// ==== rtcdt_master.sv ====
// Register-bus master model that sets and reads the date and time block.
// Assumes the block takes a strobe at the rising edge after it is raised.
`timescale 1ns/1ps
`default_nettype none
module rtcdt_master (
   input wire logic clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata
);
   // Idle bus at time zero.
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
   end
   // One write cycle; released lines show inverted values so stale data is never mistaken.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   // One read cycle.
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask : rd
   // Loads a full date and time, milliseconds zero and written last.
   task automatic set_time(input logic [7:0] m, y, h, dy, s, mi);
      wr(8'hAF, {m, y});
      wr(8'hB0, {h, dy});
      wr(8'hB1, {s, mi});
      wr(8'hB2, 16'h0000);
   endtask : set_time
endmodule : rtcdt_master
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the date and time register block.
// Assumes a 4-cycle millisecond so one second is 4000 clocks.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rtcdt_pkg::*;
   localparam int CYC_MS = 4;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr, reg_rd, reg_hit, err_status_bit, pend = 1'b0;
   logic [7:0] reg_addr;
   logic [7:0] f [6];
   logic [15:0] reg_wdata, reg_rdata;
   logic [31:0] err_word;
   logic [31:0] seed = 32'h0000_0059;
   logic [15:0] exp_q [$];
   int n_fail = 0;
   int samples_checked = 0;
   always #5 clk = ~clk;
   rtcdt_master mst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   rtcdt_regs #(.CYC_PER_MS(CYC_MS)) dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .err_status_bit(err_status_bit), .err_word(err_word));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   // Compares one value and counts it.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xorshift
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test
   // Notes the expected read data, then reads.
   task automatic rd_exp(input logic [7:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      mst.rd(a);
   endtask : rd_exp
   // Checks the invalid-time flag and the error word.
   task automatic err_is(input logic e);
      repeat (2) @(posedge clk);
      #2;
      check("err_status_bit", {31'h0, err_status_bit}, {31'h0, e});
      check("err_word", err_word, {23'h0, e, 8'h00});
   endtask : err_is
   // Watches reads: address decode at the strobe, data one cycle later.
   always @(posedge clk) begin
      #2;
      if (pend) begin
         check("reg_rdata", {16'h0000, reg_rdata}, {16'h0000, exp_q.pop_front()});
      end
      pend = reg_rd;
      if (reg_rd) begin
         check("reg_hit", {31'h0, reg_hit}, {31'h0, (reg_addr >= 8'hAF && reg_addr <= 8'hB2)});
      end
   end
   // Cuts a hang short.
   initial begin
      #300000;
      n_fail++;
      stop_test();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      err_is(1'b1);
      rd_exp(RTCDT_ADDR_MY, 16'h0000);
      rd_exp(8'h40, 16'h0000);
      $display("reset test done");
      mst.set_time(8'h01, 8'h18, 8'h0A, 8'h0F, 8'h1E, 8'h05);
      err_is(1'b0);
      rd_exp(RTCDT_ADDR_MY, 16'h0118);
      rd_exp(RTCDT_ADDR_HD, 16'h0A0F);
      rd_exp(RTCDT_ADDR_SM, 16'h1E05);
      mst.wr(RTCDT_ADDR_MY, 16'h0C32);
      mst.wr(8'h40, 16'hFFFF);
      rd_exp(RTCDT_ADDR_MY, 16'h0118);
      repeat (4100) @(posedge clk);
      rd_exp(RTCDT_ADDR_SM, 16'h1F05);
      $display("set and count test done");
      mst.set_time(8'h0C, 8'h0A, 8'h17, 8'h1F, 8'h3B, 8'h3B);
      repeat (4100) @(posedge clk);
      rd_exp(RTCDT_ADDR_MY, 16'h010B);
      rd_exp(RTCDT_ADDR_HD, 16'h0001);
      rd_exp(RTCDT_ADDR_SM, 16'h0000);
      mst.set_time(8'h05, 8'h14, 8'h18, 8'h0A, 8'h00, 8'h00);
      rd_exp(RTCDT_ADDR_HD, 16'h000A);
      $display("rollover test done");
      // Bad month, year past 50, day 32, then 29 February of a non-leap year.
      for (int i = 0; i < 4; i++) begin
         f[0] = (i == 0) ? 8'h0D : 8'h02;
         f[1] = (i == 1) ? 8'h33 : 8'h01;
         f[3] = (i == 2) ? 8'h20 : ((i == 3) ? 8'h1D : 8'h01);
         mst.set_time(f[0], f[1], 8'h00, f[3], 8'h00, 8'h00);
         err_is(1'b1);
      end
      // 29 February of a leap year is a valid date.
      mst.set_time(8'h02, 8'h18, 8'h00, 8'h1D, 8'h00, 8'h00);
      err_is(1'b0);
      $display("range test done");
      for (int i = 0; i < 3; i++) begin
         f[0] = 8'(xorshift() % 12 + 1);
         f[1] = 8'(xorshift() % 51);
         f[2] = 8'(xorshift() % 24);
         f[3] = 8'(xorshift() % 28 + 1);
         f[4] = 8'(xorshift() % 60);
         f[5] = 8'(xorshift() % 60);
         mst.set_time(f[0], f[1], f[2], f[3], f[4], f[5]);
         err_is(1'b0);
         rd_exp(RTCDT_ADDR_MY, {f[0], f[1]});
         rd_exp(RTCDT_ADDR_HD, {f[2], f[3]});
         rd_exp(RTCDT_ADDR_SM, {f[4], f[5]});
         // The read is taken ten clocks after the commit, so whole milliseconds have passed.
         rd_exp(RTCDT_ADDR_MS, 16'(10 / CYC_MS));
      end
      $display("random test done");
      // Loss of the backup store mid-run; the master must set the clock again.
      @(posedge clk);
      #1;
      sys_rst = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      err_is(1'b1);
      rd_exp(RTCDT_ADDR_SM, 16'h0000);
      mst.set_time(8'h07, 8'h19, 8'h08, 8'h1E, 8'h00, 8'h00);
      err_is(1'b0);
      rd_exp(RTCDT_ADDR_HD, 16'h081E);
      $display("outage test done");
      repeat (3) @(posedge clk);
      stop_test();
   end
endmodule : tb
`default_nettype wire
